//--- logic/axs_bank.sv
// Auxiliary interrupt flags and error flags of the reader front end.
// Assumes register strobes and error event pulses from same-clock logic.
// Contract
// - Write with bit 7 high sets marked flags; bit 7 low clears them.
// - Any edge on the serial input sets the serial edge flag.
// - CRC calculate done with all data processed sets CRC done flag.
// - Aux flags stay set until software clears them.
// - Host FIFO write during authenticate or reply window flags violation.
// - Overheat sets its flag and switches antenna drivers off.
// - Any write into full FIFO sets overflow error.
// - Collision flag sets on collision, clears at rx start, zero above 106.
// - CRC error sets on failed check when enabled, clears at rx start.
// - Parity error sets on failure at 106, clears at rx start.
// - Frame start error sets on bad SOF at 106, clears at rx start.
// - During authenticate a wrong byte count sets frame start error.
// - Command start clears all errors except overheat.
// - Software writes never touch the overheat flag.
// - Error flags show status of the most recent command.
// - Summary error irq is high while any error flag is set.
// - CRC and edge flags reach the irq only when enabled.
`timescale 1ns/1ps
`include "axs_defs.svh"
module axs_bank (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Register port
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [5:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_hit,
  // Interrupt enables from the enable register
  input wire logic i_crc_done_irq_enable,
  input wire logic i_serial_in_edge_irq_enable,
  // Pin
  input wire logic i_contactless_serial_input,
  // Command and receiver context
  input wire logic i_cmd_start,
  input wire logic i_card_authenticate_command,
  input wire logic i_crc_calculate_command,
  input wire logic i_crc_all_processed,
  input wire logic i_rx_startup,
  input wire logic i_reply_window,
  input wire axs_pkg::axs_rate_t i_rate,
  input wire logic i_rx_crc_check_enable,
  // Error events
  input wire logic i_host_fifo_wr,
  input wire logic i_fifo_full,
  input wire logic i_int_fifo_wr,
  input wire logic i_overheat,
  input wire logic i_collision,
  input wire logic i_crc_fail,
  input wire logic i_parity_fail,
  input wire logic i_sof_bad,
  input wire logic i_auth_len_bad,
  // Status out
  output logic [7:0] o_aux_interrupt_flags,
  output logic [7:0] o_error_flags,
  output logic o_summary_error_irq,
  output logic o_aux_irq,
  output logic o_antenna_off
);
  logic [7:0] aux_r;
  logic [7:0] aux_nxt;
  logic [7:0] err_r;
  logic [7:0] err_nxt;
  logic [7:0] hw_set;
  logic serial_edge;
  logic aux_wr;
  logic low_rate;

  // Shared address decode for read and write
  function automatic logic addr_is(input logic [5:0] a, input logic [5:0] r);
    addr_is = (a == r);
  endfunction : addr_is

  axs_edge_det i_axs_edge_det (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_pin(i_contactless_serial_input),
    .o_edge(serial_edge)
  );

  assign aux_wr = i_reg_wr && addr_is(i_reg_addr, `AXS_AUX_IRQ_ADDR);
  assign low_rate = (i_rate == axs_pkg::AXS_RATE_106);

  // Aux flag next value: software edit first, hardware set wins afterwards
  always_comb begin
    aux_nxt = aux_r;
    if (aux_wr) begin
      if (i_reg_wdata[`AXS_SET_SEL_BIT]) begin
        aux_nxt = aux_r | (i_reg_wdata & `AXS_AUX_MASK);
      end else begin
        aux_nxt = aux_r & ~(i_reg_wdata & `AXS_AUX_MASK);
      end
    end
    if (serial_edge) begin
      aux_nxt[`AXS_EDGE_IRQ_BIT] = 1'b1;
    end
    if (i_crc_calculate_command && i_crc_all_processed) begin
      aux_nxt[`AXS_CRC_IRQ_BIT] = 1'b1;
    end
  end

  // Aux flags only change by software or by their set events
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      aux_r <= `AXS_AUX_RST;
    end else begin
      aux_r <= aux_nxt;
    end
  end

  // Error set terms, each but overheat gated by its validity condition
  always_comb begin
    hw_set = 8'h00;
    hw_set[`AXS_WR_VIOL_BIT] = i_host_fifo_wr
      && (i_card_authenticate_command || i_reply_window);
    hw_set[`AXS_HEAT_BIT] = i_overheat;
    hw_set[`AXS_OVFL_BIT] = i_fifo_full && (i_host_fifo_wr || i_int_fifo_wr);
    hw_set[`AXS_COLL_BIT] = i_collision && low_rate;
    hw_set[`AXS_CRC_ERR_BIT] = i_crc_fail && i_rx_crc_check_enable;
    hw_set[`AXS_PAR_BIT] = i_parity_fail && low_rate;
    hw_set[`AXS_SOF_BIT] = (i_sof_bad && low_rate)
      || (i_auth_len_bad && i_card_authenticate_command);
  end

  // Clears first (command start, receiver start-up), then sets win
  always_comb begin
    err_nxt = err_r;
    if (i_cmd_start) begin
      err_nxt = err_r & (8'h01 << `AXS_HEAT_BIT);
    end
    if (i_rx_startup) begin
      err_nxt[`AXS_COLL_BIT] = 1'b0;
      err_nxt[`AXS_CRC_ERR_BIT] = 1'b0;
      err_nxt[`AXS_PAR_BIT] = 1'b0;
      err_nxt[`AXS_SOF_BIT] = 1'b0;
    end
    if (!low_rate) begin
      err_nxt[`AXS_COLL_BIT] = 1'b0;
    end
    err_nxt = err_nxt | hw_set;
    err_nxt[`AXS_ERR_RSVD_BIT] = 1'b0; // Reserved position always reads zero
  end

  // Error register has no write path, so overheat is immune to software
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      err_r <= `AXS_ERR_RST;
    end else begin
      err_r <= err_nxt;
    end
  end

  // Antenna shutdown follows the overheat flag
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_antenna_off <= 1'b0;
    end else begin
      o_antenna_off <= err_nxt[`AXS_HEAT_BIT];
    end
  end

  // Read data registered; unmapped addresses read zero
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      if (addr_is(i_reg_addr, `AXS_AUX_IRQ_ADDR)) begin
        o_reg_rdata <= aux_r;
      end else if (addr_is(i_reg_addr, `AXS_ERROR_ADDR)) begin
        o_reg_rdata <= err_r;
      end else begin
        o_reg_rdata <= 8'h00;
      end
    end
  end

  assign o_reg_hit = addr_is(i_reg_addr, `AXS_AUX_IRQ_ADDR)
    || addr_is(i_reg_addr, `AXS_ERROR_ADDR);
  assign o_aux_interrupt_flags = aux_r;
  assign o_error_flags = err_r;
  // Summary level for the primary interrupt register
  assign o_summary_error_irq = |err_r;
  // Gated request for the interrupt pin logic
  assign o_aux_irq = (aux_r[`AXS_CRC_IRQ_BIT] && i_crc_done_irq_enable)
    || (aux_r[`AXS_EDGE_IRQ_BIT] && i_serial_in_edge_irq_enable);

  // Set byte sets the marked flag on the next edge
  property p_aux_set;
    @(posedge i_clk) disable iff (i_sys_rst)
    aux_wr && i_reg_wdata[7] && i_reg_wdata[2] |=> aux_r[2];
  endproperty
  a_aux_set: assert property (p_aux_set) else $error("aux set failed");

  // Clear byte clears unless an event lands in the same cycle
  property p_aux_clr;
    @(posedge i_clk) disable iff (i_sys_rst)
    aux_wr && !i_reg_wdata[7] && i_reg_wdata[4] && !serial_edge |=> !aux_r[4];
  endproperty
  a_aux_clr: assert property (p_aux_clr) else $error("aux clear failed");

  property p_aux_keep;
    @(posedge i_clk) disable iff (i_sys_rst)
    aux_wr && !i_reg_wdata[2] && !(i_crc_calculate_command && i_crc_all_processed)
      |=> aux_r[2] == $past(aux_r[2]);
  endproperty
  a_aux_keep: assert property (p_aux_keep) else $error("unmarked flag changed");

  property p_edge;
    @(posedge i_clk) disable iff (i_sys_rst)
    $changed(i_contactless_serial_input) |-> ##[3:4] aux_r[4];
  endproperty
  a_edge: assert property (p_edge) else $error("edge flag missing");

  property p_crc_done;
    @(posedge i_clk) disable iff (i_sys_rst)
    i_crc_calculate_command && i_crc_all_processed |=> aux_r[2];
  endproperty
  a_crc_done: assert property (p_crc_done) else $error("crc done flag missing");

  property p_sticky;
    @(posedge i_clk) disable iff (i_sys_rst)
    aux_r[4] && !aux_wr |=> aux_r[4];
  endproperty
  a_sticky: assert property (p_sticky) else $error("aux flag dropped");

  property p_cmd_clear;
    @(posedge i_clk) disable iff (i_sys_rst)
    i_cmd_start && hw_set == 8'h00 |=> (err_r & 8'hBF) == 8'h00;
  endproperty
  a_cmd_clear: assert property (p_cmd_clear) else $error("command start left errors");

  property p_heat_keep;
    @(posedge i_clk) disable iff (i_sys_rst)
    err_r[6] |=> err_r[6];
  endproperty
  a_heat_keep: assert property (p_heat_keep) else $error("overheat flag cleared");

  // Checked on the next edge, so a command start right behind the event cannot trip it
  property p_ovfl;
    @(posedge i_clk) disable iff (i_sys_rst)
    i_fifo_full && (i_host_fifo_wr || i_int_fifo_wr)
      |=> err_r[`AXS_OVFL_BIT] && o_summary_error_irq;
  endproperty
  a_ovfl: assert property (p_ovfl) else $error("overflow not flagged");

  property p_coll_rate;
    @(posedge i_clk) disable iff (i_sys_rst)
    !low_rate |=> !err_r[3];
  endproperty
  a_coll_rate: assert property (p_coll_rate) else $error("collision at high rate");

  // Set byte also sets the serial edge flag
  property p_aux_set_edge;
    @(posedge i_clk) disable iff (i_sys_rst)
    aux_wr && i_reg_wdata[`AXS_SET_SEL_BIT] && i_reg_wdata[`AXS_EDGE_IRQ_BIT]
      |=> aux_r[`AXS_EDGE_IRQ_BIT];
  endproperty
  a_aux_set_edge: assert property (p_aux_set_edge) else $error("edge set failed");

  // Clear byte drops the CRC flag unless the CRC event lands in the same cycle
  property p_aux_clr_crc;
    @(posedge i_clk) disable iff (i_sys_rst)
    aux_wr && !i_reg_wdata[`AXS_SET_SEL_BIT] && i_reg_wdata[`AXS_CRC_IRQ_BIT]
      && !(i_crc_calculate_command && i_crc_all_processed) |=> !aux_r[`AXS_CRC_IRQ_BIT];
  endproperty
  a_aux_clr_crc: assert property (p_aux_clr_crc) else $error("crc clear failed");

  // Reserved aux positions can never be written to one
  property p_aux_rsvd;
    @(posedge i_clk) disable iff (i_sys_rst)
    (aux_r & ~`AXS_AUX_MASK) == 8'h00;
  endproperty
  a_aux_rsvd: assert property (p_aux_rsvd) else $error("reserved aux bit set");

  // CRC done flag is sticky as well
  property p_sticky_crc;
    @(posedge i_clk) disable iff (i_sys_rst)
    aux_r[`AXS_CRC_IRQ_BIT] && !aux_wr |=> aux_r[`AXS_CRC_IRQ_BIT];
  endproperty
  a_sticky_crc: assert property (p_sticky_crc) else $error("crc flag dropped");

  // Host FIFO write in a locked window raises the violation flag
  property p_wr_viol;
    @(posedge i_clk) disable iff (i_sys_rst)
    i_host_fifo_wr && (i_card_authenticate_command || i_reply_window)
      |=> err_r[`AXS_WR_VIOL_BIT];
  endproperty
  a_wr_viol: assert property (p_wr_viol) else $error("write violation missing");

  // Overheat sets its flag and the antenna shutdown together
  property p_heat_set;
    @(posedge i_clk) disable iff (i_sys_rst)
    i_overheat |=> err_r[`AXS_HEAT_BIT] && o_antenna_off;
  endproperty
  a_heat_set: assert property (p_heat_set) else $error("overheat not acted on");

  // Receiver start-up with no new event leaves the four receive errors clear
  property p_rx_clear;
    @(posedge i_clk) disable iff (i_sys_rst)
    i_rx_startup && (hw_set & `AXS_RX_CLR_MASK) == 8'h00
      |=> (err_r & `AXS_RX_CLR_MASK) == 8'h00;
  endproperty
  a_rx_clear: assert property (p_rx_clear) else $error("rx errors kept");

  // Enabled CRC check failure flags an error
  property p_crc_err;
    @(posedge i_clk) disable iff (i_sys_rst)
    i_crc_fail && i_rx_crc_check_enable |=> err_r[`AXS_CRC_ERR_BIT];
  endproperty
  a_crc_err: assert property (p_crc_err) else $error("crc error missing");

  // Parity failure at the lowest rate flags an error
  property p_par;
    @(posedge i_clk) disable iff (i_sys_rst)
    i_parity_fail && low_rate |=> err_r[`AXS_PAR_BIT];
  endproperty
  a_par: assert property (p_par) else $error("parity error missing");

  // Bad start of frame at the lowest rate flags an error
  property p_sof;
    @(posedge i_clk) disable iff (i_sys_rst)
    i_sof_bad && low_rate |=> err_r[`AXS_SOF_BIT];
  endproperty
  a_sof: assert property (p_sof) else $error("frame start error missing");

  // Wrong byte count while authenticating flags a frame-start error at any rate
  property p_auth_len;
    @(posedge i_clk) disable iff (i_sys_rst)
    i_auth_len_bad && i_card_authenticate_command |=> err_r[`AXS_SOF_BIT];
  endproperty
  a_auth_len: assert property (p_auth_len) else $error("auth length error missing");

  // Overheat flag only rises on a sensor event, never on a register write
  property p_heat_src;
    @(posedge i_clk) disable iff (i_sys_rst)
    !err_r[`AXS_HEAT_BIT] && !i_overheat |=> !err_r[`AXS_HEAT_BIT];
  endproperty
  a_heat_src: assert property (p_heat_src) else $error("overheat set without event");

  // Summary line tracks the error byte in the same cycle
  property p_summary;
    @(posedge i_clk) disable iff (i_sys_rst)
    o_summary_error_irq == (err_r != 8'h00);
  endproperty
  a_summary: assert property (p_summary) else $error("summary irq wrong");

  // With both enables low the aux request stays quiet whatever the flags
  property p_aux_irq;
    @(posedge i_clk) disable iff (i_sys_rst)
    !i_crc_done_irq_enable && !i_serial_in_edge_irq_enable |-> !o_aux_irq;
  endproperty
  a_aux_irq: assert property (p_aux_irq) else $error("aux irq not gated");
endmodule : axs_bank

//--- logic/axs_defs.svh
// Register offsets, field positions and reset values for the aux irq / error bank.
// Assumes inclusion by the bank module only.
`ifndef AXS_DEFS_SVH
`define AXS_DEFS_SVH
`define AXS_AUX_IRQ_ADDR 6'h05
`define AXS_ERROR_ADDR 6'h06
`define AXS_SET_SEL_BIT 7
`define AXS_EDGE_IRQ_BIT 4
`define AXS_CRC_IRQ_BIT 2
`define AXS_WR_VIOL_BIT 7
`define AXS_HEAT_BIT 6
`define AXS_OVFL_BIT 4
`define AXS_COLL_BIT 3
`define AXS_CRC_ERR_BIT 2
`define AXS_PAR_BIT 1
`define AXS_SOF_BIT 0
`define AXS_AUX_RST 8'h00
`define AXS_ERR_RST 8'h00
`define AXS_AUX_MASK 8'h14
`define AXS_RX_CLR_MASK 8'h0F
`define AXS_ERR_RSVD_BIT 5
`endif

//--- logic/axs_pkg.sv
// Types shared by the aux irq / error bank.
// Assumes nothing of its surroundings.
package axs_pkg;
  typedef enum logic [1:0] {AXS_RATE_106, AXS_RATE_212, AXS_RATE_424, AXS_RATE_848} axs_rate_t;
endpackage : axs_pkg

//--- logic/axs_edge_det.sv
// Two-flop synchroniser and both-edge detector for the serial input pin.
// Assumes an asynchronous pin input and a single system clock.
`timescale 1ns/1ps
module axs_edge_det (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Pin and event
  input wire logic i_pin,
  output logic o_edge
);
  logic meta_r;
  logic sync_r;
  logic last_r;

  // First flop feeds only the second, to keep metastability off the logic
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
    end else begin
      meta_r <= i_pin;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  // Either direction of change counts
  assign o_edge = sync_r ^ last_r;
endmodule : axs_edge_det

//--- bench/axs_host.sv
// Host model: drives single-byte register reads and writes into the bank.
// Assumes the bench calls wr and rd hierarchically, one at a time.
`timescale 1ns/1ps
module axs_host (
  // Clock
  input wire logic i_clk,
  // Register port toward the bank
  output logic o_reg_wr,
  output logic o_reg_rd,
  output logic [5:0] o_reg_addr,
  output logic [7:0] o_reg_wdata,
  input wire logic [7:0] i_reg_rdata
);
  // Idle lines show the inverse of the last value so stale data never looks valid
  initial begin
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_addr = 6'h3F;
    o_reg_wdata = 8'hFF;
  end
  // Aux flags drop only through these writes, never by the bank itself
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge i_clk);
    #1;
    o_reg_wr = 1'b1;
    o_reg_addr = a;
    o_reg_wdata = d;
    @(posedge i_clk);
    #1;
    o_reg_wr = 1'b0;
    o_reg_addr = ~a;
    o_reg_wdata = ~d;
  endtask : wr
  // Read data is registered, so it is taken after the strobe edge has landed
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge i_clk);
    #1;
    o_reg_rd = 1'b1;
    o_reg_addr = a;
    @(posedge i_clk);
    #1;
    o_reg_rd = 1'b0;
    o_reg_addr = ~a;
    d = i_reg_rdata;
  endtask : rd
endmodule : axs_host

//--- bench/axs_bank_bench.sv
// Self-checking bench for the aux irq and error flag bank.
// Assumes the host model in axs_host.sv and a 100 MHz system clock.
`timescale 1ns/1ps
module axs_bank_bench;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic wr, rd, hit, s_irq, a_irq, ant;
  logic [5:0] addr;
  logic [7:0] wd, rdat, v, aux, err;
  logic c_ien = 1'b0, e_ien = 1'b0, pin = 1'b0, auth = 1'b0, calc = 1'b0;
  logic reply = 1'b0, crc_en = 1'b0, full = 1'b0;
  axs_pkg::axs_rate_t rate = axs_pkg::AXS_RATE_106;
  // Event pulses, one bit each, so a test fires several at once
  logic [10:0] ev = 11'h000;
  int fails = 0;
  int n_tests = 0;
  axs_host i_axs_host (.i_clk(i_clk), .o_reg_wr(wr), .o_reg_rd(rd), .o_reg_addr(addr),
    .o_reg_wdata(wd), .i_reg_rdata(rdat));
  axs_bank i_axs_bank (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(addr), .i_reg_wdata(wd), .o_reg_rdata(rdat), .o_reg_hit(hit),
    .i_crc_done_irq_enable(c_ien), .i_serial_in_edge_irq_enable(e_ien),
    .i_contactless_serial_input(pin), .i_cmd_start(ev[8]),
    .i_card_authenticate_command(auth), .i_crc_calculate_command(calc),
    .i_crc_all_processed(ev[10]), .i_rx_startup(ev[9]), .i_reply_window(reply),
    .i_rate(rate), .i_rx_crc_check_enable(crc_en), .i_host_fifo_wr(ev[0]),
    .i_fifo_full(full), .i_int_fifo_wr(ev[1]), .i_overheat(ev[2]), .i_collision(ev[3]),
    .i_crc_fail(ev[4]), .i_parity_fail(ev[5]), .i_sof_bad(ev[6]), .i_auth_len_bad(ev[7]),
    .o_aux_interrupt_flags(aux), .o_error_flags(err), .o_summary_error_irq(s_irq),
    .o_aux_irq(a_irq), .o_antenna_off(ant));
  initial begin
    forever #5 i_clk = ~i_clk;
  end
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("mismatch t=%0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  // Address decode seen on every strobe; only the two flag registers answer
  always @(posedge i_clk) begin
    if (rd || wr) begin
      chk({7'h00, hit}, {7'h00, (addr == 6'h05) || (addr == 6'h06)});
    end
  end
  // One-cycle pulse; the flags have settled when this returns
  task automatic fire(input logic [10:0] m);
    @(posedge i_clk);
    #1;
    ev = m;
    @(posedge i_clk);
    #1;
    ev = 11'h000;
  endtask : fire
  task automatic final_report();
    $display("tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report
  // Watchdog: the sequence needs well under a thousand cycles
  initial begin
    #100000;
    fails++;
    final_report();
  end
  initial begin
    repeat (3) @(posedge i_clk);
    #1;
    i_sys_rst = 1'b0;
    i_axs_host.rd(6'h05, v);
    chk(v, 8'h00);
    i_axs_host.rd(6'h06, v);
    chk(v, 8'h00);
    i_axs_host.rd(6'h10, v);
    chk(v, 8'h00);
    // Reserved bits ignore writes
    i_axs_host.wr(6'h05, 8'hFF);
    chk(aux, 8'h14);
    chk({7'h00, a_irq}, 8'h00);
    e_ien = 1'b1;
    #1;
    chk({7'h00, a_irq}, 8'h01);
    i_axs_host.wr(6'h05, 8'h04);
    chk(aux, 8'h10);
    c_ien = 1'b1;
    i_axs_host.wr(6'h05, 8'h10);
    chk({a_irq, aux[6:0]}, 8'h00);
    // Rising then falling pin edge, each through the synchroniser
    pin = 1'b1;
    repeat (6) @(posedge i_clk);
    #1;
    chk(aux, 8'h10);
    repeat (20) @(posedge i_clk);
    i_axs_host.rd(6'h05, v);
    chk(v, 8'h10);
    i_axs_host.wr(6'h05, 8'h10);
    pin = 1'b0;
    repeat (6) @(posedge i_clk);
    #1;
    chk(aux, 8'h10);
    i_axs_host.wr(6'h05, 8'h10);
    calc = 1'b1;
    fire(11'h400);
    chk({a_irq, aux[6:0]}, 8'h84);
    calc = 1'b0;
    auth = 1'b1;
    fire(11'h001);
    chk(err, 8'h80);
    chk({7'h00, s_irq}, 8'h01);
    fire(11'h080);
    chk(err, 8'h81);
    auth = 1'b0;
    fire(11'h100);
    chk({s_irq, err[6:0]}, 8'h00);
    chk(aux, 8'h04);
    reply = 1'b1;
    fire(11'h001);
    chk(err, 8'h80);
    reply = 1'b0;
    fire(11'h102);
    chk(err, 8'h00);
    full = 1'b1;
    fire(11'h002);
    chk(err, 8'h10);
    fire(11'h100);
    fire(11'h001);
    chk(err, 8'h10);
    full = 1'b0;
    fire(11'h018);
    chk(err, 8'h18);
    crc_en = 1'b1;
    fire(11'h070);
    chk(err, 8'h1F);
    fire(11'h200);
    chk(err, 8'h10);
    // Higher rates refuse collision, parity and frame-start events
    rate = axs_pkg::AXS_RATE_212;
    fire(11'h068);
    chk(err, 8'h10);
    rate = axs_pkg::AXS_RATE_424;
    fire(11'h008);
    chk(err, 8'h10);
    rate = axs_pkg::AXS_RATE_848;
    fire(11'h068);
    chk(err, 8'h10);
    auth = 1'b1;
    fire(11'h080);
    chk(err, 8'h11);
    auth = 1'b0;
    i_axs_host.rd(6'h06, v);
    chk(v, 8'h11);
    fire(11'h004);
    chk({ant, err[6:0]}, 8'hD1);
    i_axs_host.wr(6'h06, 8'h00);
    chk(err, 8'h51);
    fire(11'h100);
    chk(err, 8'h40);
    final_report();
  end
endmodule : axs_bank_bench
